//--- core/pdf_pkg.sv
// Function
// - Setting the init done bit enables periodic mode and the optional diagnostic mode.
// - Diagnostic mode off: answer only a one-bit broadcast read, either bit value.
// - Diagnostic commands arrive in two- or four-bit fragments, chosen by the size bit.
// - Diagnostic mode on: answer exactly on broadcast read or a matching fragment.
// - Broadcast read or a length other than two or four restarts fragment assembly.
// - Diagnostic response only after a full 32-bit command that decodes as valid.
// - Assembled commands get the normal command check; broadcast reads get none.
// - Frame order: source id, keep-alive, status, sensor data, 8-bit CRC; format sizes fields.
// - Enabled source id field carries the 4-bit identifier of that source.
// - Keep-alive is a 2-bit counter per source, from zero, one step per message.
// - Sensor data field carries the kind chosen by that source's data selector.
// - Enabled status field is a 4-bit code from the status table.
// - Codes 0000 to 0101 are normal through temperature error, priorities 16 to 11.
// - Codes 1000 to 1101 are memory, test, supply, reset errors, priorities 8 to 3.
// - Supply error: silent until timer expires, then error data unless disabled.
// - Four-bit status: priorities 11-16 keep live data, 8 and below send error data.
// - Zero-size status: any non-normal condition sends error data at least once.
// - CRC over whole frame, MSB first, then eight zeros leave the CRC.
// - CRC polynomial x^8+x^5+x^3+x^2+x+1, seed four zeros then source identifier.
package pdf_pkg;

	localparam int NUM_SRC   = 2;
	localparam int SRC_W     = 1;
	localparam int NUM_KIND  = 2;
	localparam int SID_W     = 4;
	localparam int KAC_W     = 2;
	localparam int STAT_W    = 4;
	localparam int DATA_W    = 10;
	localparam int CRC_W     = 8;
	localparam int FMT_W     = 3;
	localparam int FRAME_W   = SID_W + KAC_W + STAT_W + DATA_W;
	localparam int LEN_W     = 5;
	localparam int CMD_W     = 32;
	localparam int CMD_LEN_W = 6;
	localparam int REG_W     = 32;
	localparam int ADDR_W    = 4;
	localparam int NUM_COND  = 11;

	localparam int FRAG_BITS_SHORT = 2;
	localparam int FRAG_BITS_LONG  = 4;
	localparam logic [CMD_LEN_W-1:0] BCAST_LEN  = 6'h01;
	localparam logic [CMD_LEN_W-1:0] FRAG_SHORT = 6'h02;
	localparam logic [CMD_LEN_W-1:0] FRAG_LONG  = 6'h04;
	localparam logic [CMD_LEN_W-1:0] CMD_FULL   = 6'h20;

	localparam logic [CRC_W-1:0] CRC_POLY = 8'h2F;
	localparam logic [3:0]       SEED_PAD = 4'h0;
	localparam logic [KAC_W-1:0] KAC_ONE  = 2'h1;

	localparam logic [ADDR_W-1:0] REG_DEVICE_LOCK_WRITE = 4'h0;
	localparam logic [ADDR_W-1:0] REG_SRC_BASE          = 4'h4;
	localparam logic [ADDR_W-1:0] REG_SRC_STEP          = 4'h4;
	localparam logic [ADDR_W-1:0] REG_STATE             = 4'hC;

	localparam int CTRL_INIT_DONE   = 0;
	localparam int CTRL_DIAG_EN     = 1;
	localparam int CTRL_FRAG_SIZE   = 2;
	localparam int CTRL_SUPPLY_ERROR_DISABLE = 3;
	localparam int SRC_ID_LSB       = 0;
	localparam int SRC_FMT_LSB      = 4;
	localparam int SRC_DSEL_BIT     = 7;
	localparam int STATE_KAC_LSB    = 0;
	localparam int STATE_STAT_LSB   = 8;
	localparam int STATE_ASM_LSB    = 12;
	localparam int STATE_BUSY_BIT   = 20;

	localparam int FMT_SID  = 0;
	localparam int FMT_KAC  = 1;
	localparam int FMT_STAT = 2;
	localparam logic [FMT_W-1:0] FMT_RESET = 3'h7;

	localparam int STAT_SEV_BIT = 3;
	localparam logic [STAT_W-1:0] ST_NORMAL   = 4'h0;
	localparam logic [STAT_W-1:0] ST_UNLOCKED = 4'h1;
	localparam logic [STAT_W-1:0] ST_SELFTEST = 4'h2;
	localparam logic [STAT_W-1:0] ST_OSC      = 4'h3;
	localparam logic [STAT_W-1:0] ST_CLIP     = 4'h4;
	localparam logic [STAT_W-1:0] ST_TEMP     = 4'h5;
	localparam logic [STAT_W-1:0] ST_UOTP     = 4'h8;
	localparam logic [STAT_W-1:0] ST_URW      = 4'h9;
	localparam logic [STAT_W-1:0] ST_FOTP     = 4'hA;
	localparam logic [STAT_W-1:0] ST_TEST     = 4'hB;
	localparam logic [STAT_W-1:0] ST_SUPPLY   = 4'hC;
	localparam logic [STAT_W-1:0] ST_RESET    = 4'hD;

	// Index 0 is the most urgent condition
	localparam logic [NUM_COND-1:0][STAT_W-1:0] COND_CODE = {ST_UNLOCKED, ST_SELFTEST, ST_OSC, ST_CLIP, ST_TEMP,
		ST_UOTP, ST_URW, ST_FOTP, ST_TEST, ST_SUPPLY, ST_RESET};

	typedef enum logic [3:0]
	{
		S_IDLE = 4'b0001,
		S_MSG  = 4'b0010,
		S_PAD  = 4'b0100,
		S_DONE = 4'b1000
	} pdf_state_t;

	typedef struct packed
	{
		pdf_state_t                        state;
		logic                              initDoneBit;
		logic                              diagEn;
		logic                              diagFragmentSize;
		logic                              supplyErrorDisable;
		logic [NUM_SRC-1:0][SID_W-1:0]     sourceIdentifier;
		logic [NUM_SRC-1:0][FMT_W-1:0]     fmt;
		logic [NUM_SRC-1:0]                dataSelector;
		logic [NUM_SRC-1:0][KAC_W-1:0]     keepaliveCounter;
		logic [NUM_SRC-1:0]                errPend;
		logic [CMD_W-1:0]                  asmWord;
		logic [CMD_LEN_W-1:0]              asmBits;
		logic                              diagDone;
		logic [CMD_W-1:0]                  diagWord;
		logic                              diagStart;
		logic [FRAME_W-1:0]                shFrame;
		logic [LEN_W-1:0]                  bitLeft;
		logic [SRC_W-1:0]                  curSrc;
		logic                              respValid;
		logic [FRAME_W-1:0]                respFrame;
		logic [LEN_W-1:0]                  respLen;
		logic [CRC_W-1:0]                  respCrc;
		logic [STAT_W-1:0]                 respStatus;
		logic [DATA_W-1:0]                 respData;
		logic [KAC_W-1:0]                  respKac;
		logic [REG_W-1:0]                  rdData;
	} pdf_core_t;

	localparam pdf_core_t CORE_RESET = '{state: S_IDLE, fmt: {NUM_SRC{FMT_RESET}}, default: '0};

	typedef struct packed
	{
		logic [CRC_W-1:0] crc;
	} pdf_crc_t;

endpackage : pdf_pkg

//--- core/pdf_crc_if.sv
`timescale 1ns/1ps
interface pdf_crc_if
	import pdf_pkg::*;
();
	logic             load;
	logic [CRC_W-1:0] seed;
	logic             shiftEn;
	logic             dataBit;
	logic [CRC_W-1:0] crc;

	modport ctl (output load, output seed, output shiftEn, output dataBit, input crc);
	modport eng (input load, input seed, input shiftEn, input dataBit, output crc);
endinterface : pdf_crc_if

//--- core/pdf_crc.sv
`timescale 1ns/1ps
module pdf_crc
	import pdf_pkg::*;
(
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst_n,
	// Serial engine
	pdf_crc_if.eng    crcBus
);
	pdf_crc_t st;
	pdf_crc_t next_st;

	always_comb
	begin
		next_st = st;
		if (crcBus.load)
			next_st.crc = crcBus.seed;
		else if (crcBus.shiftEn)
			next_st.crc = {st.crc[CRC_W-2:0], crcBus.dataBit} ^ (st.crc[CRC_W-1] ? CRC_POLY : '0);
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign crcBus.crc = st.crc;

endmodule : pdf_crc

//--- core/pdf_framer.sv
`timescale 1ns/1ps
module pdf_framer
	import pdf_pkg::*;
#(
	parameter logic [DATA_W-1:0] DATA_ERR_CODE = 10'h200
)(
	// Clock and reset
	input  wire logic                                     mclk,
	input  wire logic                                     rst_n,
	// Register port
	input  wire logic [ADDR_W-1:0]                        regAddr,
	input  wire logic [REG_W-1:0]                         regWrData,
	input  wire logic                                     regWrite,
	input  wire logic                                     regRead,
	output      logic [REG_W-1:0]                         regRdData,
	// Received command
	input  wire logic                                     cmdValid,
	input  wire logic [CMD_LEN_W-1:0]                     cmdLen,
	input  wire logic [CMD_W-1:0]                         cmdBits,
	input  wire logic [SRC_W-1:0]                         cmdSrc,
	// Device conditions
	input  wire logic                                     resetOccurredFlag,
	input  wire logic                                     supplyErr,
	input  wire logic                                     supplyTimerDone,
	input  wire logic                                     testModeFlag,
	input  wire logic                                     factoryOtpErr,
	input  wire logic                                     userRwErr,
	input  wire logic                                     userOtpErr,
	input  wire logic                                     tempErr,
	input  wire logic                                     signalClipped,
	input  wire logic                                     offsetErr,
	input  wire logic                                     oscTrainErr,
	input  wire logic                                     selftestIncomplete,
	input  wire logic                                     selftestRunning,
	input  wire logic                                     selftestFailed,
	input  wire logic                                     userUnlocked,
	// Sensor data per source and kind
	input  wire logic [NUM_SRC-1:0][NUM_KIND-1:0][DATA_W-1:0] sensorData,
	// Periodic response
	output      logic                                     respValid,
	output      logic [FRAME_W-1:0]                       respFrame,
	output      logic [LEN_W-1:0]                         respLen,
	output      logic [CRC_W-1:0]                         respCrc,
	output      logic [SRC_W-1:0]                         respSrc,
	// Diagnostic command
	output      logic                                     diagCmdDone,
	output      logic [CMD_W-1:0]                         diagCmd,
	input  wire logic                                     diagCheckOk,
	output      logic                                     diagRespStart
);
	pdf_core_t            st;
	pdf_core_t            next_st;
	logic [NUM_COND-1:0]  condVec;
	logic [STAT_W-1:0]    statusCode;
	logic                 supplyLive;
	logic [NUM_SRC-1:0]   replaceCond;
	logic                 diagOn;
	logic [CMD_LEN_W-1:0] fragLen;
	logic                 bcastCmd;
	logic                 lenIsFrag;
	logic                 fragCmd;
	logic                 silent;
	logic                 trigger;
	logic [FRAME_W-1:0]   frameAcc;
	logic [LEN_W-1:0]     frameLen;
	logic [DATA_W-1:0]    dataField;
	logic [REG_W-1:0]     rdMux;

	pdf_crc_if crcBus ();

	pdf_crc uCrc
	(
		.mclk   (mclk),
		.rst_n  (rst_n),
		.crcBus (crcBus)
	);

	function automatic logic [STAT_W-1:0] pickStatus(input logic [NUM_COND-1:0] cond);
		logic [STAT_W-1:0] code;
		code = ST_NORMAL;
		for (int i = NUM_COND - 1; i >= 0; i--)
		begin
			if (cond[i])
				code = COND_CODE[i];
		end
		return code;
	endfunction : pickStatus

	// Supply error only counts once its monitor timer has run out
	assign condVec = {userUnlocked, selftestIncomplete | selftestRunning | selftestFailed, oscTrainErr,
		signalClipped | offsetErr, tempErr, userOtpErr, userRwErr, factoryOtpErr, testModeFlag,
		supplyErr & supplyTimerDone, resetOccurredFlag};
	assign statusCode = pickStatus(condVec);
	assign supplyLive = (statusCode == ST_SUPPLY) & st.supplyErrorDisable;

	for (genvar s = 0; s < NUM_SRC; s++)
	begin : gRepl
		assign replaceCond[s] = ~supplyLive & (st.fmt[s][FMT_STAT] ? statusCode[STAT_SEV_BIT]
			: (statusCode != ST_NORMAL));
	end

	assign diagOn    = st.initDoneBit & st.diagEn;
	assign fragLen   = st.diagFragmentSize ? FRAG_LONG : FRAG_SHORT;
	assign bcastCmd  = cmdValid & (cmdLen == BCAST_LEN);
	assign lenIsFrag = (cmdLen == FRAG_SHORT) | (cmdLen == FRAG_LONG);
	assign fragCmd   = diagOn & cmdValid & (cmdLen == fragLen);
	assign silent    = supplyErr & ~supplyTimerDone;
	// Commands that arrive while a frame is still being built are not answered
	assign trigger   = st.initDoneBit & (bcastCmd | fragCmd) & ~silent & (st.state == S_IDLE);

	always_comb
	begin
		next_st = st;
		next_st.respValid = 1'b0;
		next_st.diagDone = 1'b0;
		next_st.diagStart = st.diagDone & diagCheckOk;
		if (regWrite)
		begin
			if (regAddr == REG_DEVICE_LOCK_WRITE)
			begin
				// Lock bit: once set it stays until reset
				next_st.initDoneBit = st.initDoneBit | regWrData[CTRL_INIT_DONE];
				next_st.diagEn = regWrData[CTRL_DIAG_EN];
				next_st.diagFragmentSize = regWrData[CTRL_FRAG_SIZE];
				next_st.supplyErrorDisable = regWrData[CTRL_SUPPLY_ERROR_DISABLE];
			end
			for (int s = 0; s < NUM_SRC; s++)
			begin
				if (regAddr == ADDR_W'(REG_SRC_BASE + s * REG_SRC_STEP))
				begin
					next_st.sourceIdentifier[s] = regWrData[SRC_ID_LSB +: SID_W];
					next_st.fmt[s] = regWrData[SRC_FMT_LSB +: FMT_W];
					next_st.dataSelector[s] = regWrData[SRC_DSEL_BIT];
				end
			end
		end
		rdMux = '0;
		case (regAddr)
			REG_DEVICE_LOCK_WRITE:
			begin
				rdMux[CTRL_INIT_DONE] = st.initDoneBit;
				rdMux[CTRL_DIAG_EN] = st.diagEn;
				rdMux[CTRL_FRAG_SIZE] = st.diagFragmentSize;
				rdMux[CTRL_SUPPLY_ERROR_DISABLE] = st.supplyErrorDisable;
			end
			REG_STATE:
			begin
				rdMux[STATE_KAC_LSB +: NUM_SRC*KAC_W] = st.keepaliveCounter;
				rdMux[STATE_STAT_LSB +: STAT_W] = st.respStatus;
				rdMux[STATE_ASM_LSB +: CMD_LEN_W] = st.asmBits;
				rdMux[STATE_BUSY_BIT] = (st.state != S_IDLE);
			end
			default:
				rdMux = '0;
		endcase
		for (int s = 0; s < NUM_SRC; s++)
		begin
			if (regAddr == ADDR_W'(REG_SRC_BASE + s * REG_SRC_STEP))
			begin
				rdMux[SRC_ID_LSB +: SID_W] = st.sourceIdentifier[s];
				rdMux[SRC_FMT_LSB +: FMT_W] = st.fmt[s];
				rdMux[SRC_DSEL_BIT] = st.dataSelector[s];
			end
		end
		next_st.rdData = regRead ? rdMux : '0;

		// Fragments shift in oldest first; the check on the full word is external
		if (fragCmd)
		begin
			if (st.diagFragmentSize)
				next_st.asmWord = {st.asmWord[CMD_W-FRAG_BITS_LONG-1:0], cmdBits[FRAG_BITS_LONG-1:0]};
			else
				next_st.asmWord = {st.asmWord[CMD_W-FRAG_BITS_SHORT-1:0], cmdBits[FRAG_BITS_SHORT-1:0]};
			next_st.asmBits = st.asmBits + fragLen;
			if (next_st.asmBits == CMD_FULL)
			begin
				next_st.diagDone = 1'b1;
				next_st.diagWord = next_st.asmWord;
				next_st.asmBits = '0;
			end
		end
		else if (~diagOn | (cmdValid & (bcastCmd | ~lenIsFrag)))
		begin
			next_st.asmBits = '0;
			next_st.asmWord = '0;
		end

		// Pending error data survives a condition that clears before the next frame
		for (int s = 0; s < NUM_SRC; s++)
			next_st.errPend[s] = replaceCond[s] | (st.errPend[s] & ~((st.state == S_DONE) & (st.curSrc == SRC_W'(s))));

		frameAcc = '0;
		frameLen = '0;
		if (st.fmt[cmdSrc][FMT_SID])
		begin
			frameAcc = {frameAcc[FRAME_W-SID_W-1:0], st.sourceIdentifier[cmdSrc]};
			frameLen = frameLen + LEN_W'(SID_W);
		end
		if (st.fmt[cmdSrc][FMT_KAC])
		begin
			frameAcc = {frameAcc[FRAME_W-KAC_W-1:0], st.keepaliveCounter[cmdSrc]};
			frameLen = frameLen + LEN_W'(KAC_W);
		end
		if (st.fmt[cmdSrc][FMT_STAT])
		begin
			frameAcc = {frameAcc[FRAME_W-STAT_W-1:0], statusCode};
			frameLen = frameLen + LEN_W'(STAT_W);
		end
		dataField = (replaceCond[cmdSrc] | st.errPend[cmdSrc]) ? DATA_ERR_CODE
			: sensorData[cmdSrc][st.dataSelector[cmdSrc]];
		frameAcc = {frameAcc[FRAME_W-DATA_W-1:0], dataField};
		frameLen = frameLen + LEN_W'(DATA_W);

		case (st.state)
			S_IDLE:
			begin
				if (trigger)
				begin
					next_st.state = S_MSG;
					next_st.shFrame = frameAcc << (LEN_W'(FRAME_W) - frameLen);
					next_st.bitLeft = frameLen;
					next_st.curSrc = cmdSrc;
					next_st.respFrame = frameAcc << (LEN_W'(FRAME_W) - frameLen);
					next_st.respLen = frameLen;
					next_st.respStatus = statusCode;
					next_st.respData = dataField;
					next_st.respKac = st.keepaliveCounter[cmdSrc];
				end
			end
			S_MSG:
			begin
				next_st.shFrame = {st.shFrame[FRAME_W-2:0], 1'b0};
				next_st.bitLeft = st.bitLeft - LEN_W'(1);
				if (st.bitLeft == LEN_W'(1))
				begin
					next_st.state = S_PAD;
					next_st.bitLeft = LEN_W'(CRC_W);
				end
			end
			S_PAD:
			begin
				next_st.bitLeft = st.bitLeft - LEN_W'(1);
				if (st.bitLeft == LEN_W'(1))
					next_st.state = S_DONE;
			end
			S_DONE:
			begin
				next_st.state = S_IDLE;
				next_st.respValid = 1'b1;
				next_st.respCrc = crcBus.crc;
				next_st.keepaliveCounter[st.curSrc] = st.keepaliveCounter[st.curSrc] + KAC_ONE;
			end
			default:
				next_st.state = S_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			st <= CORE_RESET;
		else
			st <= next_st;
	end

	assign crcBus.load    = trigger;
	assign crcBus.seed    = {SEED_PAD, st.sourceIdentifier[cmdSrc]};
	assign crcBus.shiftEn = (st.state == S_MSG) | (st.state == S_PAD);
	assign crcBus.dataBit = (st.state == S_MSG) & st.shFrame[FRAME_W-1];

	assign regRdData     = st.rdData;
	assign respValid     = st.respValid;
	assign respFrame     = st.respFrame;
	assign respLen       = st.respLen;
	assign respCrc       = st.respCrc;
	assign respSrc       = st.curSrc;
	assign diagCmdDone   = st.diagDone;
	assign diagCmd       = st.diagWord;
	assign diagRespStart = st.diagStart;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	sequence s_pad_run;
		(st.state == S_PAD) [*8] ##1 (st.state == S_DONE);
	endsequence

	sequence s_emit;
		##1 respValid;
	endsequence

	property p_lock_gate;
		cmdValid && !st.initDoneBit |=> st.state == S_IDLE;
	endproperty
	a_lock_gate: assert property (p_lock_gate) else $error("response started before init done");

	property p_bcast_answer;
		bcastCmd && st.initDoneBit && !silent && st.state == S_IDLE |=> st.state == S_MSG;
	endproperty
	a_bcast_answer: assert property (p_bcast_answer) else $error("broadcast read not answered");

	property p_exact_answer;
		cmdValid && st.state == S_IDLE && !bcastCmd && !fragCmd |=> st.state == S_IDLE;
	endproperty
	a_exact_answer: assert property (p_exact_answer) else $error("answered a non-fragment command");

	property p_frag_clear;
		cmdValid && (bcastCmd || !lenIsFrag) |=> st.asmBits == '0;
	endproperty
	a_frag_clear: assert property (p_frag_clear) else $error("fragment assembly not restarted");

	property p_diag_start;
		diagRespStart |-> $past(st.diagDone) && $past(diagCheckOk);
	endproperty
	a_diag_start: assert property (p_diag_start) else $error("diagnostic response without valid command");

	property p_crc_tail;
		$rose(st.state == S_PAD) |-> s_pad_run ##0 s_emit;
	endproperty
	a_crc_tail: assert property (p_crc_tail) else $error("CRC not closed by eight zero bits");

	property p_keepalive;
		respValid |-> st.keepaliveCounter[st.curSrc] == st.respKac + KAC_ONE;
	endproperty
	a_keepalive: assert property (p_keepalive) else $error("keep-alive counter did not step");

	property p_source_field;
		respValid && st.fmt[st.curSrc][FMT_SID] |-> respFrame[FRAME_W-1 -: SID_W] == st.sourceIdentifier[st.curSrc];
	endproperty
	a_source_field: assert property (p_source_field) else $error("source id field wrong");

	property p_supply_silent;
		cmdValid && silent && st.state == S_IDLE |=> st.state == S_IDLE;
	endproperty
	a_supply_silent: assert property (p_supply_silent) else $error("answered during supply hold-off");

	property p_err_data;
		trigger && replaceCond[cmdSrc] |=> st.respData == DATA_ERR_CODE;
	endproperty
	a_err_data: assert property (p_err_data) else $error("error code not substituted");

	property p_reset_priority;
		trigger && resetOccurredFlag |=> st.respStatus == ST_RESET;
	endproperty
	a_reset_priority: assert property (p_reset_priority) else $error("status priority wrong");

endmodule : pdf_framer

//--- tb/pdf_master_model.sv
`timescale 1ns/1ps
module pdf_master_model
	import pdf_pkg::*;
(
	// Clock and request
	input  wire logic                 mclk,
	input  wire logic                 go,
	input  wire logic [CMD_LEN_W-1:0] len,
	input  wire logic [CMD_W-1:0]     bits,
	input  wire logic [SRC_W-1:0]     src,
	// Command slot
	output      logic                 cmdValid,
	output      logic [CMD_LEN_W-1:0] cmdLen,
	output      logic [CMD_W-1:0]     cmdBits,
	output      logic [SRC_W-1:0]     cmdSrc
);
	initial {cmdValid, cmdLen, cmdBits, cmdSrc} = '0;
	// Idle slot toggles, so stale fields never pass for a command
	always @(posedge mclk)
	begin
		cmdValid <= go;
		cmdLen   <= go ? len : ~cmdLen;
		cmdBits  <= go ? bits : ~cmdBits;
		cmdSrc   <= go ? src : ~cmdSrc;
	end
endmodule : pdf_master_model

//--- tb/periodic_data_diag_framer_test.sv
`timescale 1ns/1ps
module periodic_data_diag_framer_test
	import pdf_pkg::*;
;
	logic                 mclk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, go = 1'b0;
	logic [ADDR_W-1:0]    regAddr = '0;
	logic [REG_W-1:0]     regWrData = '0, regRdData;
	logic [CMD_LEN_W-1:0] len = '0, cmdLen;
	logic [CMD_W-1:0]     bits = '0, cmdBits, diagCmd, lastCmd = '0;
	logic [SRC_W-1:0]     src = '0, cmdSrc, respSrc;
	logic [14:0]          cond = '0;
	logic [1:0][1:0][9:0] sensorData = '0;
	logic                 cmdValid, respValid, diagCmdDone, diagRespStart, diagCheckOk = 1'b0, okWant = 1'b1;
	logic [19:0]          respFrame;
	logic [4:0]           respLen;
	logic [7:0]           respCrc;
	logic [3:0]           ctl = '0;
	logic [1:0][3:0]      sid = '0;
	logic [1:0][2:0]      fmt = 6'h3F;
	logic [1:0][1:0]      keepalive_counter = '0;
	logic [1:0]           dsel = '0, pend = '0;
	int                   badCount = 0, nChecks = 0, cyc = 0, doneCnt = 0, startCnt = 0;

	pdf_master_model master (.mclk(mclk), .go(go), .len(len), .bits(bits), .src(src),
		.cmdValid(cmdValid), .cmdLen(cmdLen), .cmdBits(cmdBits), .cmdSrc(cmdSrc));
	pdf_framer DUT (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
		.regRead(regRead), .regRdData(regRdData), .cmdValid(cmdValid), .cmdLen(cmdLen), .cmdBits(cmdBits),
		.cmdSrc(cmdSrc), .resetOccurredFlag(cond[14]), .supplyErr(cond[13]), .supplyTimerDone(cond[12]),
		.testModeFlag(cond[11]), .factoryOtpErr(cond[10]), .userRwErr(cond[9]), .userOtpErr(cond[8]),
		.tempErr(cond[7]), .signalClipped(cond[6]), .offsetErr(cond[5]), .oscTrainErr(cond[4]),
		.selftestIncomplete(cond[3]), .selftestRunning(cond[2]), .selftestFailed(cond[1]),
		.userUnlocked(cond[0]), .sensorData(sensorData), .respValid(respValid), .respFrame(respFrame),
		.respLen(respLen), .respCrc(respCrc), .respSrc(respSrc), .diagCmdDone(diagCmdDone),
		.diagCmd(diagCmd), .diagCheckOk(diagCheckOk), .diagRespStart(diagRespStart));

	always #20 mclk = ~mclk;

	task automatic stopTest();
		if (badCount == 0 && nChecks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stopTest

	always @(posedge mclk)
	begin
		cyc         <= cyc + 1;
		diagCheckOk <= okWant;
		doneCnt     <= doneCnt + int'(diagCmdDone === 1'b1);
		startCnt    <= startCnt + int'(diagRespStart === 1'b1);
		if (diagCmdDone === 1'b1)
			lastCmd <= diagCmd;
		if (cyc == 20000)
		begin
			badCount++;
			stopTest();
		end
	end

	task automatic check(logic [31:0] got, logic [31:0] exp);
		nChecks++;
		if (got !== exp)
		begin
			badCount++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	function automatic logic [3:0] expStat(logic [14:0] c);
		logic [10:0] u;
		logic [3:0]  code [11];
		code = '{4'hD, 4'hC, 4'hB, 4'hA, 4'h9, 4'h8, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1};
		u = {c[0], |c[3:1], c[4], |c[6:5], c[7], c[8], c[9], c[10], c[11], c[13] & c[12], c[14]};
		for (int i = 0; i < 11; i++)
			if (u[i]) return code[i];
		return 4'h0;
	endfunction : expStat

	// Augmented form: message then eight zeros through the register
	function automatic logic [7:0] expCrc(logic [19:0] f, int n, logic [3:0] id);
		logic [7:0] c;
		c = {4'h0, id};
		for (int i = 0; i < n + 8; i++)
			c = {c[6:0], (i < n) ? f[19-i] : 1'b0} ^ (c[7] ? 8'h2F : 8'h00);
		return c;
	endfunction : expCrc

	task automatic wr(logic [3:0] a, logic [31:0] d);
		@(posedge mclk);
		regAddr   <= a;
		regWrData <= d;
		regWrite  <= 1'b1;
		@(posedge mclk);
		regWrite  <= 1'b0;
	endtask : wr

	task automatic rd(logic [3:0] a, logic [31:0] e);
		@(posedge mclk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge mclk);
		regRead <= 1'b0;
		#1;
		check(regRdData, e);
	endtask : rd

	task automatic cfgSrc(int s, logic [3:0] id, logic [2:0] f, logic d);
		sid[s]  = id;
		fmt[s]  = f;
		dsel[s] = d;
		wr(4'(4 + 4 * s), {24'h0, d, f, id});
	endtask : cfgSrc

	task automatic send(logic [5:0] l, logic [31:0] b, logic s, logic [14:0] c, logic e);
		logic [19:0] f;
		logic [3:0]  st;
		logic [9:0]  d;
		logic        sub;
		logic        got;
		int          n;
		@(posedge mclk);
		go         <= 1'b1;
		len        <= l;
		bits       <= b;
		src        <= s;
		cond       <= c;
		sensorData <= 40'({$urandom(), $urandom()});
		@(posedge mclk);
		go  <= 1'b0;
		got = 1'b0;
		for (int i = 0; i < 40 && !got; i++)
		begin
			@(posedge mclk);
			#1;
			got = (respValid === 1'b1);
		end
		check(got, e);
		if (got && e)
		begin
			st  = expStat(cond);
			d   = sensorData[s][dsel[s]];
			sub = (fmt[s][2] ? st[3] : st != 4'h0) && !(st == 4'hC && ctl[3]);
			if (sub || pend[s])
				d = 10'h200;
			pend[s] = sub;
			f = fmt[s][0] ? 20'(sid[s]) : 20'h0;
			if (fmt[s][1])
				f = (f << 2) | 20'(keepalive_counter[s]);
			if (fmt[s][2])
				f = (f << 4) | 20'(st);
			f = (f << 10) | 20'(d);
			n = 10 + 4 * fmt[s][0] + 2 * fmt[s][1] + 4 * fmt[s][2];
			f = f << (20 - n);
			check(respFrame, f);
			check(respLen, n);
			check(respCrc, expCrc(f, n, sid[s]));
			check(respSrc, s);
			keepalive_counter[s] = keepalive_counter[s] + 2'h1;
		end
	endtask : send

	task automatic frags(logic [31:0] w, int sz, int cnt);
		for (int i = 0; i < cnt; i++)
			send(6'(sz), (w >> (32 - sz * (i + 1))) & ((32'h1 << sz) - 1), 1'b0, 15'h0, 1'b1);
	endtask : frags

	initial
	begin
		logic [31:0] w;
		void'($urandom(32'h0574861C));
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		rd(4'h8, 32'h70);
		rd(4'h1, 32'h0);
		check(expCrc(20'h1C1FF, 20, 4'h1), 32'hD6);
		send(6'h01, 32'h1, 1'b0, 15'h0, 1'b0);
		ctl = 4'h1;
		wr(4'h0, 32'h1);
		cfgSrc(0, 4'h1, 3'h7, 1'b0);
		for (int i = 0; i < 6; i++)
			send(6'h01, 32'(i[0]), 1'b0, 15'h0, 1'b1);
		send(6'h02, 32'h1, 1'b0, 15'h0, 1'b0);
		cfgSrc(1, 4'($urandom()), 3'h6, 1'b1);
		send(6'h01, 32'h0, 1'b1, 15'h0, 1'b1);
		cfgSrc(1, sid[1], 3'h3, 1'b1);
		send(6'h01, 32'h0, 1'b1, 15'h1001, 1'b1);
		send(6'h01, 32'h0, 1'b1, 15'h1000, 1'b1);
		for (int k = 0; k < 15; k++)
		begin
			send(6'h01, 32'h1, 1'b0, 15'(1 << k) | 15'h1000, 1'b1);
			send(6'h01, 32'h1, 1'b0, 15'h1000, 1'b1);
		end
		repeat (8) send(6'h01, 32'h0, 1'b0, 15'($urandom()) | 15'h1000, 1'b1);
		send(6'h01, 32'h0, 1'b0, 15'h2000, 1'b0);
		ctl = 4'h9;
		wr(4'h0, 32'h9);
		send(6'h01, 32'h0, 1'b0, 15'h3000, 1'b1);
		// Supply error must be gone before substitution is re-enabled
		@(posedge mclk);
		cond <= '0;
		ctl = 4'h3;
		wr(4'h0, 32'h3);
		send(6'h02, 32'h2, 1'b0, 15'h0, 1'b1);
		send(6'h03, 32'h5, 1'b0, 15'h0, 1'b0);
		send(6'h04, 32'h5, 1'b0, 15'h0, 1'b0);
		w = $urandom();
		frags(~w, 2, 3);
		send(6'h01, 32'h0, 1'b0, 15'h0, 1'b1);
		frags(w, 2, 16);
		check(doneCnt, 1);
		check(lastCmd, w);
		check(startCnt, 1);
		repeat (4) send(6'h01, 32'h1, 1'b0, 15'h0, 1'b1);
		ctl = 4'h7;
		wr(4'h0, 32'h7);
		okWant = 1'b0;
		w = $urandom();
		frags(w, 4, 8);
		check(doneCnt, 2);
		check(lastCmd, w);
		check(startCnt, 1);
		repeat (8) send(6'h01, 32'h0, 1'b0, 15'h0, 1'b1);
		rd(4'hC, 32'(keepalive_counter));
		wr(4'h0, 32'h0);
		rd(4'h0, 32'h1);
		stopTest();
	end
endmodule : periodic_data_diag_framer_test
